// File: shared/pin_mode_pkg.sv
// constants and types for the type-c control pin mode logic
// Functional notes
// - floating strap selects standalone gpio mode
// - low strap enables bus, address 0x47
// - high strap enables bus, address 0x67
// - bus mode: open-drain low interrupt on change
// - gpio mode: interrupt pin low on accessory
// - bus mode: dual pins carry data, clock
// - gpio ufp: flag a low medium/high current
// - gpio ufp: flag b low high current
// - attach output low on dfp attach
// - enable input active low
// - orientation high position 2, low 1
package pin_mode_pkg;
    typedef enum logic [1:0] {
        STRAP_LOW,
        STRAP_HIGH,
        STRAP_FLOAT
    } strap_type;

    typedef enum logic [1:0] {
        CUR_DEFAULT,
        CUR_MEDIUM,
        CUR_HIGH
    } current_type;

    localparam logic [6:0] ADDR_STRAP_LOW    = 7'h47;
    localparam logic [6:0] ADDR_STRAP_HIGH   = 7'h67;
    // apb register byte offsets
    localparam logic [7:0] OFS_STATUS        = 8'h00;
    localparam logic [7:0] OFS_MASK          = 8'h04;
    localparam logic [7:0] OFS_PINS          = 8'h08;
    localparam logic [7:0] OFS_MODE          = 8'h0C;
    localparam logic [7:0] OFS_CHANGE        = 8'h10;
    // event bit positions in status and mask
    localparam int         EV_MODE           = 0;
    localparam int         EV_ATTACH         = 1;
    localparam int         EV_ACCESSORY      = 2;
    localparam int         EV_ENABLE         = 3;
    localparam int         EV_WIDTH          = 4;
    localparam logic [3:0] MASK_RESET        = 4'h0;
    localparam logic [1:0] SYNC_STAGES       = 2'h2;
endpackage

// File: hdl/pin_sync.sv
// two flip-flop synchroniser for a group of pin levels
module pin_sync
    import pin_mode_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clocking
    input  wire logic             mclk,
    input  wire logic             rstSync_n,
    input  wire logic             clkEn,
    // levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1_ff <= '0;
            syncOut   <= '0;
        end else if (clkEn) begin
            stage1_ff <= asyncIn;
            syncOut   <= stage1_ff;
        end
    end
endmodule

// File: hdl/apb_regs.sv
// apb slave for status, mask, pin readback and mode registers
module apb_regs
    import pin_mode_pkg::*;
(
    // clocking
    input  wire logic                mclk,
    input  wire logic                rstSync_n,
    input  wire logic                clkEn,
    // apb
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // block side
    input  wire logic [EV_WIDTH-1:0] events,
    input  wire logic [31:0]         pinView,
    input  wire logic [31:0]         modeView,
    output logic      [EV_WIDTH-1:0] status_ff,
    output logic      [EV_WIDTH-1:0] mask_ff,
    output logic                     writeSeen
);
    logic access;
    logic known;
    logic [31:0] nxt_prdata;

    function automatic logic isMapped(input logic [7:0] a);
        return a == OFS_STATUS || a == OFS_MASK || a == OFS_PINS || a == OFS_MODE;
    endfunction

    assign access = psel && penable && pready;
    assign known  = isMapped(paddr);

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            OFS_STATUS: nxt_prdata = {{(32-EV_WIDTH){1'b0}}, status_ff};
            OFS_MASK:   nxt_prdata = {{(32-EV_WIDTH){1'b0}}, mask_ff};
            OFS_PINS:   nxt_prdata = pinView;
            OFS_MODE:   nxt_prdata = modeView;
            default:    nxt_prdata = 32'h0000_0000;
        endcase
    end

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !known;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= nxt_prdata;
            end
        end
    end

    // set wins over the write-one clear
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            status_ff <= '0;
        end else if (clkEn) begin
            if (access && pwrite && paddr == OFS_STATUS) begin
                status_ff <= (status_ff & ~pwdata[EV_WIDTH-1:0]) | events;
            end else begin
                status_ff <= status_ff | events;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            mask_ff   <= MASK_RESET;
            writeSeen <= 1'b0;
        end else if (clkEn) begin
            writeSeen <= access && pwrite && known;
            if (access && pwrite && paddr == OFS_MASK) begin
                mask_ff <= pwdata[EV_WIDTH-1:0];
            end
        end
    end
endmodule

// File: hdl/pin_mode_logic.sv
// top of the type-c control pin mode logic
module pin_mode_logic
    import pin_mode_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // pins from outside
    input  wire logic        enable_n,
    input  wire logic [1:0]  strapLevel,
    // detection results from cc logic
    input  wire logic        ufpRole,
    input  wire logic        dfpRole,
    input  wire logic        attachDetected,
    input  wire logic [1:0]  currentLevel,
    input  wire logic        accessoryDetected,
    input  wire logic        plugPosition2,
    input  wire logic        regChange,
    // serial bus engine side, outputs to pins when in bus mode
    input  wire logic        busDataOe_n,
    input  wire logic        busClockOe_n,
    // dual-function pins, plus the attach and orientation pins
    input  wire logic        busDataIn,
    input  wire logic        busClockIn,
    output logic             busDataOrCurrentFlagA_oe_n,
    output logic             busClockOrCurrentFlagB_oe_n,
    output logic             irqOrAccessoryPin_oe_n,
    output logic             sourceAttachFlagPin_oe_n,
    output logic             orientationPin_oe_n,
    // bus mode status for the serial bus engine
    output logic             busEnable,
    output logic [6:0]       targetAddress,
    output logic             busDataSync,
    output logic             busClockSync,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq
);
    logic                rstMeta_ff;
    logic                rstSync_n;
    logic [5:0]          pinSync;
    logic                enableSync_n;
    logic [1:0]          strapSync;
    logic                dataSync;
    logic                clockSync;
    logic                active;
    strap_type           strap_ff;
    strap_type           nxt_strap;
    logic                gpioMode;
    logic [EV_WIDTH-1:0] events;
    logic [EV_WIDTH-1:0] status;
    logic [EV_WIDTH-1:0] mask;
    logic                attachPrev_ff;
    logic                accPrev_ff;
    logic                enPrev_ff;
    logic                writeSeen;
    logic                irqPending_ff;
    logic [31:0]         pinView;
    logic [31:0]         modeView;
    logic                nxtFlagA;
    logic                nxtFlagB;
    logic                nxtIrqPin;

    // reset released through two flip-flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_n  <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_n  <= rstMeta_ff;
        end
    end

    pin_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .mclk      (mclk),
        .rstSync_n (rstSync_n),
        .clkEn     (clkEn),
        .asyncIn   ({~enable_n, strapLevel, ~busDataIn, ~busClockIn, 1'b0}),
        .syncOut   (pinSync)
    );

    // enable and bus lines are stored inverted so the synchroniser's zero reset
    // reads as disabled and idle-high lines: no false bus start after reset
    assign enableSync_n = ~pinSync[5];
    assign strapSync    = pinSync[4:3];
    assign dataSync     = ~pinSync[2];
    assign clockSync    = ~pinSync[1];
    assign active       = !enableSync_n;

    // tri-level strap arrives as two comparator levels: 00 low, 11 high, else floating
    function automatic strap_type decodeStrap(input logic [1:0] lvl);
        unique case (lvl)
            2'b00:   return STRAP_LOW;
            2'b11:   return STRAP_HIGH;
            default: return STRAP_FLOAT;
        endcase
    endfunction

    assign nxt_strap = decodeStrap(strapSync);
    assign gpioMode  = (strap_ff == STRAP_FLOAT);

    // strap is followed while disabled and frozen while enabled, so a glitch
    // on the pin cannot flip the mode under a live bus transfer
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            strap_ff <= STRAP_FLOAT;
        end else if (clkEn && !active) begin
            strap_ff <= nxt_strap;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busEnable     <= 1'b0;
            targetAddress <= ADDR_STRAP_LOW;
            busDataSync   <= 1'b1;
            busClockSync  <= 1'b1;
        end else if (clkEn) begin
            busEnable    <= active && !gpioMode;
            busDataSync  <= dataSync;
            busClockSync <= clockSync;
            if (strap_ff == STRAP_HIGH) begin
                targetAddress <= ADDR_STRAP_HIGH;
            end else begin
                targetAddress <= ADDR_STRAP_LOW;
            end
        end
    end

    // bus-mode interrupt latch: any register change asserts until serviced
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irqPending_ff <= 1'b0;
        end else if (clkEn) begin
            if (regChange || writeSeen) begin
                irqPending_ff <= 1'b1;
            end else if (!active || gpioMode) begin
                irqPending_ff <= 1'b0;
            end else if (psel && penable && pready && !pwrite && paddr == OFS_CHANGE) begin
                irqPending_ff <= 1'b0;
            end
        end
    end

    // current flags only mean something as a sink; otherwise released
    always_comb begin
        nxtFlagA  = 1'b1;
        nxtFlagB  = 1'b1;
        nxtIrqPin = 1'b1;
        if (!active) begin
            nxtFlagA  = 1'b1;
            nxtFlagB  = 1'b1;
            nxtIrqPin = 1'b1;
        end else if (gpioMode) begin
            nxtFlagA  = !(ufpRole && currentLevel != CUR_DEFAULT);
            nxtFlagB  = !(ufpRole && currentLevel == CUR_HIGH);
            nxtIrqPin = !accessoryDetected;
        end else begin
            nxtFlagA  = busDataOe_n;
            nxtFlagB  = busClockOe_n;
            nxtIrqPin = !irqPending_ff;
        end
    end

    // open-drain: enable low pulls the pin low, high releases it
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busDataOrCurrentFlagA_oe_n  <= 1'b1;
            busClockOrCurrentFlagB_oe_n <= 1'b1;
            irqOrAccessoryPin_oe_n      <= 1'b1;
            sourceAttachFlagPin_oe_n    <= 1'b1;
            orientationPin_oe_n         <= 1'b1;
        end else if (clkEn) begin
            busDataOrCurrentFlagA_oe_n  <= nxtFlagA;
            busClockOrCurrentFlagB_oe_n <= nxtFlagB;
            irqOrAccessoryPin_oe_n      <= nxtIrqPin;
            sourceAttachFlagPin_oe_n    <= !(active && dfpRole && attachDetected);
            orientationPin_oe_n         <= !(active && !plugPosition2);
        end
    end

    // event edges for the sticky status register
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            attachPrev_ff <= 1'b0;
            accPrev_ff    <= 1'b0;
            enPrev_ff     <= 1'b0;
        end else if (clkEn) begin
            attachPrev_ff <= attachDetected;
            accPrev_ff    <= accessoryDetected;
            enPrev_ff     <= active;
        end
    end

    assign events[EV_MODE]      = regChange;
    assign events[EV_ATTACH]    = attachDetected != attachPrev_ff;
    assign events[EV_ACCESSORY] = accessoryDetected != accPrev_ff;
    assign events[EV_ENABLE]    = active != enPrev_ff;

    assign pinView  = {26'h0, sourceAttachFlagPin_oe_n, orientationPin_oe_n, irqOrAccessoryPin_oe_n,
                       busClockOrCurrentFlagB_oe_n, busDataOrCurrentFlagA_oe_n, active};
    assign modeView = {22'h0, targetAddress, busEnable, strap_ff};

    apb_regs u_apb_regs (
        .mclk      (mclk),
        .rstSync_n (rstSync_n),
        .clkEn     (clkEn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .events    (events),
        .pinView   (pinView),
        .modeView  (modeView),
        .status_ff (status),
        .mask_ff   (mask),
        .writeSeen (writeSeen)
    );

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= |(status & mask);
        end
    end

    a_float_gpio: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && gpioMode |=> !busEnable) else $error("bus enabled in gpio mode");
    a_low_addr: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && strap_ff == STRAP_LOW |=> targetAddress == 7'h47) else $error("low strap address");
    a_high_addr: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && strap_ff == STRAP_HIGH |=> targetAddress == 7'h67) else $error("high strap address");
    a_irq_change: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && regChange && active && !gpioMode ##1 clkEn && active && !gpioMode
        |=> !irqOrAccessoryPin_oe_n) else $error("change interrupt missing");
    a_acc_pin: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && gpioMode && accessoryDetected |=> !irqOrAccessoryPin_oe_n) else $error("accessory pin");
    a_bus_data: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && !gpioMode |=> busDataOrCurrentFlagA_oe_n == $past(busDataOe_n)) else $error("bus data pin");
    a_flag_a: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && gpioMode && ufpRole && currentLevel == CUR_MEDIUM
        |=> !busDataOrCurrentFlagA_oe_n && busClockOrCurrentFlagB_oe_n) else $error("medium flags");
    a_flag_b: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && gpioMode && ufpRole && currentLevel == CUR_HIGH
        |=> !busClockOrCurrentFlagB_oe_n) else $error("high flag");
    a_attach_pin: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && dfpRole && attachDetected |=> !sourceAttachFlagPin_oe_n) else $error("attach pin");
    a_orient_pin: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active |=> orientationPin_oe_n == $past(plugPosition2)) else $error("orientation pin");
    a_off_release: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && !active |=> irqOrAccessoryPin_oe_n && sourceAttachFlagPin_oe_n && orientationPin_oe_n
        && busDataOrCurrentFlagA_oe_n && busClockOrCurrentFlagB_oe_n) else $error("pins not released");

    // strap register and bus mode
    a_strap_frozen: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active
        |=> $stable(strap_ff))
        else $error("strap changed while enabled");

    a_strap_follow: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && !active
        |=> strap_ff == $past(nxt_strap))
        else $error("strap not followed while disabled");

    a_bus_enable: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && !gpioMode
        |=> busEnable)
        else $error("bus not enabled");

    a_bus_clock: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && !gpioMode
        |=> busClockOrCurrentFlagB_oe_n == $past(busClockOe_n))
        else $error("bus clock pin");

    // status outputs in gpio mode, and the attach pin in any mode
    a_default_flags: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && gpioMode && ufpRole && currentLevel == CUR_DEFAULT
        |=> busDataOrCurrentFlagA_oe_n && busClockOrCurrentFlagB_oe_n)
        else $error("default current flags");

    a_acc_release: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && gpioMode && !accessoryDetected
        |=> irqOrAccessoryPin_oe_n)
        else $error("accessory pin not released");

    a_attach_release: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && !(dfpRole && attachDetected)
        |=> sourceAttachFlagPin_oe_n)
        else $error("attach pin not released");

    // bus interrupt latch, status, level interrupt and the clock-enable freeze
    a_bus_irq_idle: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && active && !gpioMode && !irqPending_ff
        |=> irqOrAccessoryPin_oe_n)
        else $error("interrupt pin without change");

    a_irq_hold: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && irqPending_ff && active && !gpioMode
        && !(psel && penable && pready && !pwrite && paddr == OFS_CHANGE)
        |=> irqPending_ff) else $error("interrupt dropped early");

    a_irq_level: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && (status & mask) != '0
        |=> irq)
        else $error("level interrupt missing");

    a_sticky_set: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && events[EV_ACCESSORY]
        |=> status[EV_ACCESSORY])
        else $error("status event lost");

    a_clken_freeze: assert property (@(posedge mclk) disable iff (!rstSync_n)
        !clkEn
        |=> $stable(irqOrAccessoryPin_oe_n) && $stable(irq) && $stable(busEnable))
        else $error("state moved while frozen");

    // coverage of the main scenarios
    c_gpio_acc: cover property (@(posedge mclk) active && gpioMode && accessoryDetected);
    c_bus_irq: cover property (@(posedge mclk) active && !gpioMode && !irqOrAccessoryPin_oe_n);
    c_high_addr: cover property (@(posedge mclk) busEnable && targetAddress == ADDR_STRAP_HIGH);
    c_low_addr: cover property (@(posedge mclk) busEnable && targetAddress == ADDR_STRAP_LOW);
    c_flag_high: cover property (@(posedge mclk) active && gpioMode && !busClockOrCurrentFlagB_oe_n);
endmodule

// File: tb/host_pins.sv
// pull-up resolution of the open-drain pins and strap source for the bench
module host_pins (
    // clock
    input  wire logic       mclk,
    // strap choice: 0 low, 1 high, 2 open
    input  wire logic [1:0] strapSel,
    output logic      [1:0] strapLevel,
    // open-drain enables of both parties
    input  wire logic       dataOe_n,
    input  wire logic       hostDataOe_n,
    input  wire logic       clockOe_n,
    input  wire logic       hostClockOe_n,
    // resolved lines
    output logic            dataLine,
    output logic            clockLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wobble = 1'b0;
    // an open strap settles nowhere, so the two comparators disagree and keep flipping
    always @(posedge mclk) begin
        wobble <= ~wobble;
    end
    // the high configuration is tied to the rail, never left open
    assign strapLevel = (strapSel == 2'h1) ? 2'h3 : (strapSel == 2'h0) ? 2'h0 : {wobble, ~wobble};
    // wired-and with external pull-ups
    assign dataLine   = dataOe_n & hostDataOe_n;
    assign clockLine  = clockOe_n & hostClockOe_n;
endmodule

// File: tb/testbench.sv
// self-checking bench for the type-c control pin mode logic
module testbench
    import pin_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FA = 0, FB = 1, IRQP = 2, ATT = 3, ORI = 4, BEN = 5, IRQ = 6, DSYN = 7, CSYN = 8, ADR = 9;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} apb_exp_type;
    typedef struct {int s; logic [31:0] d;} pin_exp_type;
    logic        mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, enable_n = 1'b1, chkStb = 1'b0;
    logic        ufpRole = 1'b1, dfpRole = 1'b1, attachDetected = 1'b1, accessoryDetected = 1'b1;
    logic        plugPosition2 = 1'b0, regChange = 1'b0, busDataOe_n = 1'b1, busClockOe_n = 1'b1;
    logic        hostDataOe_n = 1'b1, hostClockOe_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [1:0]  strapSel = 2'h2, currentLevel = 2'h2;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire logic   busDataIn, busClockIn, aOe, bOe, irqOe, attOe, oriOe, busEnable, busDataSync, busClockSync;
    wire logic   pready, pslverr, irq;
    wire logic [1:0]  strapLevel;
    wire logic [6:0]  targetAddress;
    wire logic [31:0] prdata;
    apb_exp_type apbQ[$];
    pin_exp_type pinQ[$];
    int          n_mismatch = 0;
    int          n_checks = 0;

    pin_mode_logic i_pin_mode_logic (.mclk, .rst_n, .clkEn, .enable_n, .strapLevel, .ufpRole, .dfpRole,
        .attachDetected, .currentLevel, .accessoryDetected, .plugPosition2, .regChange, .busDataOe_n,
        .busClockOe_n, .busDataIn, .busClockIn, .busDataOrCurrentFlagA_oe_n(aOe),
        .busClockOrCurrentFlagB_oe_n(bOe), .irqOrAccessoryPin_oe_n(irqOe), .sourceAttachFlagPin_oe_n(attOe),
        .orientationPin_oe_n(oriOe), .busEnable, .targetAddress, .busDataSync, .busClockSync, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
    host_pins i_host_pins (.mclk, .strapSel, .strapLevel, .dataOe_n(aOe), .hostDataOe_n, .clockOe_n(bOe),
        .hostClockOe_n, .dataLine(busDataIn), .clockLine(busClockIn));

    always #2.5 mclk = ~mclk;

    function automatic logic [31:0] pick(int s);
        logic [8:0] v;
        v = {busClockSync, busDataSync, irq, busEnable, oriOe, attOe, irqOe, busClockIn, busDataIn};
        return (s == ADR) ? {25'h0, targetAddress} : {31'h0, v[s]};
    endfunction
    task automatic fail(logic [31:0] got, logic [31:0] exp);
        n_mismatch++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic report_and_stop(bit late);
        if (late) n_mismatch++;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // outputs are judged on the values they held when the edge arrived
    always @(posedge mclk) begin
        apb_exp_type a;
        pin_exp_type p;
        if (psel && penable && pready === 1'b1) begin
            a = apbQ.pop_front();
            n_checks += 2;
            if ((prdata & a.m) !== (a.d & a.m)) fail(prdata, a.d);
            if (pslverr !== a.e) fail({31'h0, pslverr}, {31'h0, a.e});
        end
        if (chkStb) begin
            p = pinQ.pop_front();
            n_checks++;
            if (pick(p.s) !== p.d) fail(pick(p.s), p.d);
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge mclk);
    endtask
    // strobe held one cycle, then a quiet cycle so back-to-back calls never collide
    task automatic expect_pin(int s, logic [31:0] d);
        pinQ.push_back('{s, d});
        chkStb <= 1'b1;
        tick(1);
        chkStb <= 1'b0;
        tick(1);
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, logic [31:0] d, logic [31:0] m, logic e);
        int i;
        apbQ.push_back('{d, m, e});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        tick(1);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            tick(1);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) report_and_stop(1);
        tick(1);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] wd);
        apb(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] d, logic [31:0] m = 32'hFFFFFFFF, logic e = 1'b0);
        apb(1'b0, a, 32'h0, d, m, e);
    endtask

    initial begin
        logic [31:0] b;
        b = $urandom(58038);
        tick(10);
        rst_n <= 1'b1;
        tick(6);
        for (int k = FA; k <= ORI; k++) expect_pin(k, 32'h1);
        expect_pin(BEN, 32'h0);
        rd(OFS_MASK, {28'h0, MASK_RESET});
        // strap is only taken while disabled; a change while enabled must not stick
        for (int s = 0; s < 3; s++) begin
            enable_n <= 1'b1;
            strapSel <= 2'(s);
            tick(8);
            enable_n <= 1'b0;
            tick(8);
            expect_pin(BEN, 32'(s < 2));
            if (s < 2) expect_pin(ADR, {25'h0, s ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW});
            rd(OFS_MODE, {22'h0, s ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW, 1'(s < 2), 2'(s)}, s < 2 ? 32'h3FF : 32'h7);
            strapSel <= (s == 2) ? 2'h0 : 2'h2;
            tick(8);
            expect_pin(BEN, 32'(s < 2));
        end
        dfpRole <= 1'b0;
        for (int c = 0; c < 3; c++) begin
            currentLevel <= 2'(c);
            tick(4);
            expect_pin(FA, 32'(c == 0));
            expect_pin(FB, 32'(c != 2));
        end
        for (int i = 0; i < 4; i++) begin
            {accessoryDetected, plugPosition2} <= 2'(i);
            tick(4);
            expect_pin(IRQP, 32'(i < 2));
            expect_pin(ORI, 32'(i % 2));
        end
        dfpRole <= 1'b1;
        tick(4);
        expect_pin(ATT, 32'h0);
        dfpRole <= 1'b0;
        tick(4);
        expect_pin(ATT, 32'h1);
        // clock enable low freezes the pins although the accessory goes away
        clkEn <= 1'b0;
        accessoryDetected <= 1'b0;
        tick(4);
        expect_pin(IRQP, 32'h0);
        clkEn <= 1'b1;
        tick(4);
        expect_pin(IRQP, 32'h1);
        // sticky status, mask and level interrupt on the accessory edge
        accessoryDetected <= 1'b0;
        tick(4);
        wr(OFS_MASK, 32'h4);
        wr(OFS_STATUS, 32'hF);
        expect_pin(IRQ, 32'h0);
        accessoryDetected <= 1'b1;
        tick(4);
        expect_pin(IRQ, 32'h1);
        rd(OFS_STATUS, 32'h4, 32'h4);
        wr(OFS_MASK, 32'h0);
        expect_pin(IRQ, 32'h0);
        wr(OFS_MASK, 32'h4);
        expect_pin(IRQ, 32'h1);
        wr(OFS_STATUS, 32'h4);
        expect_pin(IRQ, 32'h0);
        rd(OFS_MASK, 32'h4);
        rd(8'h20, 32'h0, 32'hFFFFFFFF, 1'b1);
        dfpRole <= 1'b1;
        enable_n <= 1'b1;
        tick(8);
        for (int k = FA; k <= ORI; k++) expect_pin(k, 32'h1);
        strapSel <= 2'h0;
        tick(8);
        enable_n <= 1'b0;
        tick(8);
        for (int i = 0; i < 6; i++) begin
            b = $urandom;
            busDataOe_n <= b[0];
            busClockOe_n <= b[1];
            hostDataOe_n <= 1'b1;
            hostClockOe_n <= 1'b1;
            tick(4);
            expect_pin(FA, {31'h0, b[0]});
            expect_pin(FB, {31'h0, b[1]});
            busDataOe_n <= 1'b1;
            busClockOe_n <= 1'b1;
            hostDataOe_n <= b[2];
            hostClockOe_n <= b[3];
            tick(4);
            expect_pin(DSYN, {31'h0, b[2]});
            expect_pin(CSYN, {31'h0, b[3]});
        end
        regChange <= 1'b1;
        tick(1);
        regChange <= 1'b0;
        tick(3);
        expect_pin(IRQP, 32'h0);
        expect_pin(IRQP, 32'h0);
        rd(OFS_STATUS, 32'h9);
        rd(OFS_CHANGE, 32'h0, 32'hFFFFFFFF, 1'b1);
        expect_pin(IRQP, 32'h1);
        wr(OFS_MASK, 32'h0);
        tick(2);
        expect_pin(IRQP, 32'h0);
        report_and_stop(0);
    end
endmodule
